// >>> pmpg_map.vh
`ifndef PMPG_MAP_VH
`define PMPG_MAP_VH

`define PMPG_ADDR_REV_WORD    16'h8005
`define PMPG_ADDR_PART_WORD   16'h8006
`define PMPG_ADDR_CFG4_WORD   16'h800A
`define PMPG_ADDR_CFG5_WORD   16'h800B
`define PMPG_CFG_SPACE_BIT    15
`define PMPG_CFG_SPACE_LAST   16'h800B

`define PMPG_CFG_ERASED       14'h3FFF
`define PMPG_CFG4_LVP         13
`define PMPG_CFG4_SAF_LOCK    11
`define PMPG_CFG4_EE_LOCK     10
`define PMPG_CFG4_CFG_LOCK    9
`define PMPG_CFG4_BOOT_LOCK   8
`define PMPG_CFG4_APP_LOCK    7
`define PMPG_CFG4_SAF_EN      4
`define PMPG_CFG4_BOOT_EN     3
`define PMPG_CFG4_SIZE_HI     2
`define PMPG_CFG4_SIZE_LO     0
`define PMPG_CFG4_UNIMPL_MASK 14'h1060
`define PMPG_CFG5_CP          0
`define PMPG_CFG5_UNIMPL      13'h1FFF

`define PMPG_REV_FIXED        2'h2
`define PMPG_PART_FIXED       2'h3

`define PMPG_FLASH_AW         13
`define PMPG_FLASH_LAST       13'h1FFF
`define PMPG_SAF_FIRST        13'h1F80
`define PMPG_BOOT_LAST_512    13'h01FF
`define PMPG_BOOT_LAST_1K     13'h03FF
`define PMPG_BOOT_LAST_2K     13'h07FF
`define PMPG_BOOT_LAST_4K     13'h0FFF
`define PMPG_SIZE_512         3'h7
`define PMPG_SIZE_1K          3'h6
`define PMPG_SIZE_2K          3'h5

`define PMPG_RESET_VECTOR     15'h0000
`define PMPG_INTR_VECTOR      15'h0004
`define PMPG_PTR_PROG_BIT     7

`endif

// >>> pmpg_classify.v
`timescale 1ns/1ps
`include "pmpg_map.vh"

module pmpg_classify
(
  addr,
  boot_region_enable_n,
  boot_region_size_sel,
  storage_region_enable_n,
  flash_addr,
  in_boot,
  in_app,
  in_storage
);
  input  wire [14:0] addr;
  input  wire        boot_region_enable_n;
  input  wire [2:0]  boot_region_size_sel;
  input  wire        storage_region_enable_n;
  output wire [12:0] flash_addr;
  output wire        in_boot;
  output wire        in_app;
  output wire        in_storage;

  function [12:0] boot_last;
    input [2:0] sel;
    begin
      case (sel)
        `PMPG_SIZE_512: boot_last = `PMPG_BOOT_LAST_512;
        `PMPG_SIZE_1K:  boot_last = `PMPG_BOOT_LAST_1K;
        `PMPG_SIZE_2K:  boot_last = `PMPG_BOOT_LAST_2K;
        default:        boot_last = `PMPG_BOOT_LAST_4K;
      endcase
    end
  endfunction

  // Upper address bits are dropped so any access folds into the 8K array.
  assign flash_addr = addr[12:0];
  assign in_boot    = !boot_region_enable_n &&
                      (flash_addr <= boot_last(boot_region_size_sel));
  assign in_storage = !storage_region_enable_n && !in_boot &&
                      (flash_addr >= `PMPG_SAF_FIRST);
  assign in_app     = !in_boot && !in_storage;
endmodule

// >>> pmpg_ind_reader.v
`timescale 1ns/1ps
`include "pmpg_map.vh"

module pmpg_ind_reader
(
  clk_sys,
  rstn,
  ind_rd_en,
  ind_wr_en,
  pointer_high_byte,
  pointer_low_byte,
  prog_rd_data,
  ind_prog_sel,
  prog_rd_req,
  prog_rd_addr,
  ind_busy,
  ind_rd_valid,
  ind_rd_data,
  ind_wr_ignored
);
  input  wire        clk_sys;
  input  wire        rstn;
  input  wire        ind_rd_en;
  input  wire        ind_wr_en;
  input  wire [7:0]  pointer_high_byte;
  input  wire [7:0]  pointer_low_byte;
  input  wire [13:0] prog_rd_data;
  output wire        ind_prog_sel;
  output wire        prog_rd_req;
  output wire [14:0] prog_rd_addr;
  output wire        ind_busy;
  output reg         ind_rd_valid;
  output reg  [7:0]  ind_rd_data;
  output reg         ind_wr_ignored;

  reg wait_r;

  assign ind_prog_sel = pointer_high_byte[`PMPG_PTR_PROG_BIT];
  assign prog_rd_req  = ind_rd_en && ind_prog_sel && !wait_r;
  assign prog_rd_addr = {pointer_high_byte[6:0], pointer_low_byte};
  // The core holds its read for the request cycle and one more.
  assign ind_busy     = prog_rd_req || wait_r;

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wait_r         <= 1'b0;
      ind_rd_valid   <= 1'b0;
      ind_rd_data    <= 8'h00;
      ind_wr_ignored <= 1'b0;
    end
    else
    begin
      wait_r         <= prog_rd_req;
      ind_rd_valid   <= wait_r;
      if (wait_r)
        ind_rd_data <= prog_rd_data[7:0];
      ind_wr_ignored <= ind_wr_en && ind_prog_sel;
    end
  end
endmodule

// >>> pmpg_guard.v
`timescale 1ns/1ps
`include "pmpg_map.vh"

module pmpg_guard
#(
  parameter [5:0]  MAJOR_REV = 6'h01,
  parameter [5:0]  MINOR_REV = 6'h00,
  // Arbitrary part code; not tied to any real product.
  parameter [11:0] PART_CODE = 12'h5A5
)
(
  clk_sys,
  rstn,
  bulk_erase,
  nvm_wr_req,
  nvm_wr_addr,
  nvm_wr_data,
  write_error_clr,
  nvm_wr_grant,
  write_error_flag,
  cfg_rd_en,
  cfg_rd_addr,
  cfg_rd_valid,
  cfg_rd_data,
  fetch_valid,
  fetch_addr,
  fetch_flash_addr,
  exec_violation_flag_set,
  exec_violation_rst,
  exec_violation_flag_n,
  reset_vector,
  intr_vector,
  ind_rd_en,
  ind_wr_en,
  pointer_high_byte,
  pointer_low_byte,
  prog_rd_data,
  prog_rd_req,
  prog_rd_flash_addr,
  ind_prog_sel,
  ind_busy,
  ind_rd_valid,
  ind_rd_data,
  ind_wr_ignored,
  flash_read_protect_n,
  boot_region_enable_n,
  storage_region_enable_n,
  boot_region_size_sel
);
  input  wire        clk_sys;
  input  wire        rstn;
  input  wire        bulk_erase;
  input  wire        nvm_wr_req;
  input  wire [15:0] nvm_wr_addr;
  input  wire [13:0] nvm_wr_data;
  input  wire        write_error_clr;
  output reg         nvm_wr_grant;
  output reg         write_error_flag;
  input  wire        cfg_rd_en;
  input  wire [15:0] cfg_rd_addr;
  output reg         cfg_rd_valid;
  output reg  [13:0] cfg_rd_data;
  input  wire        fetch_valid;
  input  wire [14:0] fetch_addr;
  output wire [12:0] fetch_flash_addr;
  input  wire        exec_violation_flag_set;
  output reg         exec_violation_rst;
  output reg         exec_violation_flag_n;
  output wire [14:0] reset_vector;
  output wire [14:0] intr_vector;
  input  wire        ind_rd_en;
  input  wire        ind_wr_en;
  input  wire [7:0]  pointer_high_byte;
  input  wire [7:0]  pointer_low_byte;
  input  wire [13:0] prog_rd_data;
  output wire        prog_rd_req;
  output wire [12:0] prog_rd_flash_addr;
  output wire        ind_prog_sel;
  output wire        ind_busy;
  output wire        ind_rd_valid;
  output wire [7:0]  ind_rd_data;
  output wire        ind_wr_ignored;
  output wire        flash_read_protect_n;
  output wire        boot_region_enable_n;
  output wire        storage_region_enable_n;
  output wire [2:0]  boot_region_size_sel;

  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_VIO = 2'b10;

  reg  [13:0] cfg4_r;
  reg  [13:0] cfg4_nxt;
  reg  [13:0] cfg5_r;
  reg  [13:0] cfg5_nxt;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         wr_ok;
  reg  [13:0] rd_word;

  wire        app_region_write_lock_n;
  wire        boot_region_write_lock_n;
  wire        config_region_write_lock_n;
  wire        storage_write_lock_n;
  wire        fetch_boot;
  wire        fetch_app;
  wire        fetch_storage;
  wire        vio_take;
  wire        wr_boot;
  wire        wr_app;
  wire        wr_storage;
  wire [14:0] ind_addr;
  wire        wr_cfg_space;
  wire        wr_cfg4;
  wire        wr_cfg5;
  wire        wr_ident;
  wire        fetch_bad;

  assign boot_region_enable_n       = cfg4_r[`PMPG_CFG4_BOOT_EN];
  assign storage_region_enable_n    = cfg4_r[`PMPG_CFG4_SAF_EN];
  assign boot_region_size_sel       = cfg4_r[`PMPG_CFG4_SIZE_HI:`PMPG_CFG4_SIZE_LO];
  assign app_region_write_lock_n    = cfg4_r[`PMPG_CFG4_APP_LOCK];
  assign boot_region_write_lock_n   = cfg4_r[`PMPG_CFG4_BOOT_LOCK];
  assign config_region_write_lock_n = cfg4_r[`PMPG_CFG4_CFG_LOCK];
  assign storage_write_lock_n       = cfg4_r[`PMPG_CFG4_SAF_LOCK];
  assign flash_read_protect_n       = cfg5_r[`PMPG_CFG5_CP];

  assign reset_vector = `PMPG_RESET_VECTOR;
  assign intr_vector  = `PMPG_INTR_VECTOR;

  pmpg_classify u_fetch_class
  (
    .addr                    (fetch_addr),
    .boot_region_enable_n    (boot_region_enable_n),
    .boot_region_size_sel    (boot_region_size_sel),
    .storage_region_enable_n (storage_region_enable_n),
    .flash_addr              (fetch_flash_addr),
    .in_boot                 (fetch_boot),
    .in_app                  (fetch_app),
    .in_storage              (fetch_storage)
  );

  pmpg_classify u_write_class
  (
    .addr                    (nvm_wr_addr[14:0]),
    .boot_region_enable_n    (boot_region_enable_n),
    .boot_region_size_sel    (boot_region_size_sel),
    .storage_region_enable_n (storage_region_enable_n),
    .flash_addr              (),
    .in_boot                 (wr_boot),
    .in_app                  (wr_app),
    .in_storage              (wr_storage)
  );

  pmpg_ind_reader u_ind
  (
    .clk_sys           (clk_sys),
    .rstn              (rstn),
    .ind_rd_en         (ind_rd_en),
    .ind_wr_en         (ind_wr_en),
    .pointer_high_byte (pointer_high_byte),
    .pointer_low_byte  (pointer_low_byte),
    .prog_rd_data      (prog_rd_data),
    .ind_prog_sel      (ind_prog_sel),
    .prog_rd_req       (prog_rd_req),
    .prog_rd_addr      (ind_addr),
    .ind_busy          (ind_busy),
    .ind_rd_valid      (ind_rd_valid),
    .ind_rd_data       (ind_rd_data),
    .ind_wr_ignored    (ind_wr_ignored)
  );

  // Indirect pointers fold into the implemented array like fetches do.
  assign prog_rd_flash_addr = ind_addr[12:0];

  assign wr_cfg_space = nvm_wr_addr[`PMPG_CFG_SPACE_BIT];
  assign wr_cfg4      = nvm_wr_addr == `PMPG_ADDR_CFG4_WORD;
  assign wr_cfg5      = nvm_wr_addr == `PMPG_ADDR_CFG5_WORD;
  assign wr_ident     = (nvm_wr_addr == `PMPG_ADDR_REV_WORD) ||
                        (nvm_wr_addr == `PMPG_ADDR_PART_WORD);

  // Same-cycle write permission check from the decoded partition.
  always @*
  begin
    if (wr_cfg_space)
    begin
      wr_ok = config_region_write_lock_n && !wr_ident &&
              (nvm_wr_addr <= `PMPG_CFG_SPACE_LAST);
    end
    else
    begin
      wr_ok = !(wr_boot && !boot_region_write_lock_n) &&
              !(wr_app && !app_region_write_lock_n) &&
              !(wr_storage && !storage_write_lock_n);
    end
  end

  // Programming can only clear configuration bits; erase restores them.
  always @*
  begin
    cfg4_nxt = cfg4_r;
    cfg5_nxt = cfg5_r;
    if (bulk_erase)
    begin
      cfg4_nxt = `PMPG_CFG_ERASED;
      cfg5_nxt = `PMPG_CFG_ERASED;
    end
    else if (nvm_wr_req && wr_ok)
    begin
      if (wr_cfg4)
      begin
        cfg4_nxt = (cfg4_r & nvm_wr_data) | `PMPG_CFG4_UNIMPL_MASK;
        if (!boot_region_enable_n)
          cfg4_nxt[`PMPG_CFG4_SIZE_HI:`PMPG_CFG4_SIZE_LO] = boot_region_size_sel;
      end
      if (wr_cfg5)
        cfg5_nxt = {`PMPG_CFG5_UNIMPL, cfg5_r[0] & nvm_wr_data[0]};
    end
  end

  // Only the boot and application blocks are valid execution areas.
  assign fetch_bad = fetch_valid && !(fetch_boot || fetch_app);
  // The violation state masks the cycle in which the reset request is high.
  assign vio_take  = (state_r == ST_RUN) && fetch_bad;

  always @*
  begin
    case (state_r)
      ST_RUN:
        state_nxt = fetch_bad ? ST_VIO : ST_RUN;
      ST_VIO:
        state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always @*
  begin
    case (cfg_rd_addr)
      `PMPG_ADDR_REV_WORD:
        rd_word = {`PMPG_REV_FIXED, MAJOR_REV, MINOR_REV};
      `PMPG_ADDR_PART_WORD:
        rd_word = {`PMPG_PART_FIXED, PART_CODE};
      `PMPG_ADDR_CFG4_WORD:
        rd_word = cfg4_r;
      `PMPG_ADDR_CFG5_WORD:
        rd_word = {`PMPG_CFG5_UNIMPL, cfg5_r[0]};
      default:
        rd_word = 14'h0000;
    endcase
  end

  // Fuse image and execution state; rstn stands for the erased power-up image.
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cfg4_r  <= `PMPG_CFG_ERASED;
      cfg5_r  <= `PMPG_CFG_ERASED;
      state_r <= ST_RUN;
    end
    else
    begin
      cfg4_r  <= cfg4_nxt;
      cfg5_r  <= cfg5_nxt;
      state_r <= state_nxt;
    end
  end

  // Write port: grant or refusal one cycle after the request.
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      nvm_wr_grant     <= 1'b0;
      write_error_flag <= 1'b0;
    end
    else
    begin
      // An erase in the same cycle wins, so the array never sees that write.
      nvm_wr_grant <= nvm_wr_req && wr_ok && !bulk_erase;
      // A new refusal wins over a clear in the same cycle.
      if (nvm_wr_req && !wr_ok)
        write_error_flag <= 1'b1;
      else if (write_error_clr)
        write_error_flag <= 1'b0;
    end
  end

  // Read port: data is held after the valid pulse so the core may take it late.
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cfg_rd_valid <= 1'b0;
      cfg_rd_data  <= 14'h0000;
    end
    else
    begin
      cfg_rd_valid <= cfg_rd_en;
      if (cfg_rd_en)
        cfg_rd_data <= rd_word;
    end
  end

  // Violation outputs: a one-cycle reset request and a flag that software re-arms.
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      exec_violation_rst    <= 1'b0;
      exec_violation_flag_n <= 1'b1;
    end
    else
    begin
      exec_violation_rst <= vio_take;
      // A new violation wins over the re-arm in the same cycle.
      if (vio_take)
        exec_violation_flag_n <= 1'b0;
      else if (exec_violation_flag_set)
        exec_violation_flag_n <= 1'b1;
    end
  end
endmodule

// >>> pmpg_flash_model.sv
`timescale 1ns/1ps

module pmpg_flash_model (
  input  wire logic        clk_sys,
  input  wire logic        prog_rd_req,
  input  wire logic [12:0] prog_rd_flash_addr,
  output logic      [13:0] prog_rd_data
);
  initial prog_rd_data = 14'h0000;

  // Data is valid only in the cycle after a request; otherwise it toggles every cycle.
  always @(posedge clk_sys)
    if (prog_rd_req)
      prog_rd_data <= {1'b0, prog_rd_flash_addr} ^ 14'h2A5C;
    else
      prog_rd_data <= ~prog_rd_data;
endmodule

// >>> pmpg_guard_asserts.sv
`timescale 1ns/1ps

module pmpg_guard_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        bulk_erase,
  input wire logic        nvm_wr_req,
  input wire logic [15:0] nvm_wr_addr,
  input wire logic        nvm_wr_grant,
  input wire logic        write_error_flag,
  input wire logic        cfg_rd_en,
  input wire logic [15:0] cfg_rd_addr,
  input wire logic        cfg_rd_valid,
  input wire logic [13:0] cfg_rd_data,
  input wire logic        fetch_valid,
  input wire logic [14:0] fetch_addr,
  input wire logic [12:0] fetch_flash_addr,
  input wire logic        exec_violation_rst,
  input wire logic        exec_violation_flag_n,
  input wire logic [14:0] reset_vector,
  input wire logic [14:0] intr_vector,
  input wire logic        ind_wr_en,
  input wire logic [7:0]  pointer_high_byte,
  input wire logic        prog_rd_req,
  input wire logic [13:0] prog_rd_data,
  input wire logic        ind_busy,
  input wire logic        ind_rd_valid,
  input wire logic [7:0]  ind_rd_data,
  input wire logic        ind_wr_ignored,
  input wire logic        boot_region_enable_n,
  input wire logic        storage_region_enable_n,
  input wire logic [2:0]  boot_region_size_sel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_bad_fetch;
    fetch_valid && !storage_region_enable_n && fetch_addr[12:0] >= 13'h1F80 && !exec_violation_rst;
  endsequence

  sequence s_ind_walk;
    ind_busy ##1 (ind_busy && !ind_rd_valid) ##1 ind_rd_valid;
  endsequence

  a_rev_fixed: assert property (
    cfg_rd_en && cfg_rd_addr == 16'h8005 |=> cfg_rd_valid && cfg_rd_data[13:12] == 2'b10)
    else $error("revision word fixed bits wrong");
  a_part_fixed: assert property (
    cfg_rd_en && cfg_rd_addr == 16'h8006 |=> cfg_rd_valid && cfg_rd_data[13:12] == 2'b11)
    else $error("part word fixed bits wrong");
  a_cp_unimpl: assert property (
    cfg_rd_en && cfg_rd_addr == 16'h800B |=> cfg_rd_data[13:1] == 13'h1FFF)
    else $error("code protect word unused bits not one");
  a_vector_values: assert property (
    reset_vector == 15'h0000 && intr_vector == 15'h0004)
    else $error("vector address wrong");
  a_fetch_wrap: assert property (
    fetch_flash_addr == fetch_addr[12:0])
    else $error("fetch address not wrapped");
  a_exec_violation: assert property (
    s_bad_fetch |=> exec_violation_rst && !exec_violation_flag_n)
    else $error("storage fetch not flagged");
  a_rst_single: assert property (
    exec_violation_rst |=> !exec_violation_rst)
    else $error("violation reset longer than one cycle");
  a_ind_timing: assert property (
    prog_rd_req |-> s_ind_walk)
    else $error("indirect read timing wrong");
  a_ind_data: assert property (
    ind_rd_valid |-> ind_rd_data == $past(prog_rd_data[7:0]))
    else $error("indirect read data wrong");
  a_ind_wr_drop: assert property (
    ind_wr_en && pointer_high_byte[7] |=> ind_wr_ignored)
    else $error("indirect write not dropped");
  a_id_wr_refused: assert property (
    nvm_wr_req && nvm_wr_addr == 16'h8005 && !bulk_erase |=> write_error_flag && !nvm_wr_grant)
    else $error("write to ident word not refused");
  a_boot_sticky: assert property (
    !boot_region_enable_n && !bulk_erase |=> !boot_region_enable_n && $stable(boot_region_size_sel))
    else $error("boot enable or size changed without erase");
endmodule

bind pmpg_guard pmpg_guard_chk u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .bulk_erase(bulk_erase), .nvm_wr_req(nvm_wr_req),
  .nvm_wr_addr(nvm_wr_addr), .nvm_wr_grant(nvm_wr_grant), .write_error_flag(write_error_flag),
  .cfg_rd_en(cfg_rd_en), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_valid(cfg_rd_valid),
  .cfg_rd_data(cfg_rd_data), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
  .fetch_flash_addr(fetch_flash_addr), .exec_violation_rst(exec_violation_rst),
  .exec_violation_flag_n(exec_violation_flag_n), .reset_vector(reset_vector),
  .intr_vector(intr_vector), .ind_wr_en(ind_wr_en), .pointer_high_byte(pointer_high_byte),
  .prog_rd_req(prog_rd_req), .prog_rd_data(prog_rd_data), .ind_busy(ind_busy),
  .ind_rd_valid(ind_rd_valid), .ind_rd_data(ind_rd_data), .ind_wr_ignored(ind_wr_ignored),
  .boot_region_enable_n(boot_region_enable_n),
  .storage_region_enable_n(storage_region_enable_n),
  .boot_region_size_sel(boot_region_size_sel));

// >>> test_pmpg_guard.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module test_pmpg_guard;
  logic        clk_sys, rstn, bulk_erase, nvm_wr_req, write_error_clr, cfg_rd_en;
  logic        fetch_valid, exec_violation_flag_set, ind_rd_en, ind_wr_en;
  logic [15:0] nvm_wr_addr, cfg_rd_addr;
  logic [13:0] nvm_wr_data;
  logic [14:0] fetch_addr;
  logic [7:0]  pointer_high_byte, pointer_low_byte;
  wire         nvm_wr_grant, write_error_flag, cfg_rd_valid, exec_violation_rst;
  wire         exec_violation_flag_n, prog_rd_req, ind_prog_sel, ind_busy, ind_rd_valid;
  wire         ind_wr_ignored, flash_read_protect_n, boot_region_enable_n;
  wire         storage_region_enable_n;
  wire [13:0]  cfg_rd_data, prog_rd_data;
  wire [12:0]  fetch_flash_addr, prog_rd_flash_addr;
  wire [14:0]  reset_vector, intr_vector;
  wire [7:0]   ind_rd_data;
  wire [2:0]   boot_region_size_sel;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [2:0]  codes [5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h0};
  logic [12:0] lasts [5] = '{13'h01FF, 13'h03FF, 13'h07FF, 13'h0FFF, 13'h0FFF};

  // Part code is arbitrary.
  pmpg_guard #(.MAJOR_REV(6'h2A), .MINOR_REV(6'h15), .PART_CODE(12'hC3A)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .bulk_erase(bulk_erase), .nvm_wr_req(nvm_wr_req),
    .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data), .write_error_clr(write_error_clr),
    .nvm_wr_grant(nvm_wr_grant), .write_error_flag(write_error_flag), .cfg_rd_en(cfg_rd_en),
    .cfg_rd_addr(cfg_rd_addr), .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_flash_addr(fetch_flash_addr),
    .exec_violation_flag_set(exec_violation_flag_set), .exec_violation_rst(exec_violation_rst),
    .exec_violation_flag_n(exec_violation_flag_n), .reset_vector(reset_vector),
    .intr_vector(intr_vector), .ind_rd_en(ind_rd_en), .ind_wr_en(ind_wr_en),
    .pointer_high_byte(pointer_high_byte), .pointer_low_byte(pointer_low_byte),
    .prog_rd_data(prog_rd_data), .prog_rd_req(prog_rd_req),
    .prog_rd_flash_addr(prog_rd_flash_addr), .ind_prog_sel(ind_prog_sel), .ind_busy(ind_busy),
    .ind_rd_valid(ind_rd_valid), .ind_rd_data(ind_rd_data), .ind_wr_ignored(ind_wr_ignored),
    .flash_read_protect_n(flash_read_protect_n), .boot_region_enable_n(boot_region_enable_n),
    .storage_region_enable_n(storage_region_enable_n),
    .boot_region_size_sel(boot_region_size_sel));

  pmpg_flash_model u_flash (.clk_sys(clk_sys), .prog_rd_req(prog_rd_req),
    .prog_rd_flash_addr(prog_rd_flash_addr), .prog_rd_data(prog_rd_data));

  always #4 clk_sys = ~clk_sys;

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic wr(input logic [15:0] a, input logic [13:0] d, input logic g);
    @(negedge clk_sys);
    nvm_wr_req = 1;
    nvm_wr_addr = a;
    nvm_wr_data = d;
    @(negedge clk_sys);
    nvm_wr_req = 0;
    write_error_clr = 1;
    `CHK(nvm_wr_grant, g)
    `CHK(write_error_flag, !g)
    @(negedge clk_sys);
    write_error_clr = 0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [13:0] e);
    @(negedge clk_sys);
    cfg_rd_en = 1;
    cfg_rd_addr = a;
    @(negedge clk_sys);
    cfg_rd_en = 0;
    `CHK(cfg_rd_valid, 1'b1)
    `CHK(cfg_rd_data, e)
  endtask

  task automatic fetch(input logic [14:0] a, input logic v);
    @(negedge clk_sys);
    fetch_valid = 1;
    fetch_addr = a;
    @(negedge clk_sys);
    fetch_valid = 0;
    `CHK(exec_violation_rst, v)
    `CHK(exec_violation_flag_n, !v)
    `CHK(fetch_flash_addr, a[12:0])
  endtask

  task automatic erase;
    @(negedge clk_sys);
    bulk_erase = 1;
    @(negedge clk_sys);
    bulk_erase = 0;
    `CHK(boot_region_enable_n, 1'b1)
  endtask

  task automatic ir(input logic [7:0] hi, input logic [7:0] lo);
    int n;
    @(negedge clk_sys);
    ind_rd_en = 1;
    pointer_high_byte = hi;
    pointer_low_byte = lo;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (ind_rd_valid !== 1'b1 && n < 8);
    ind_rd_en = 0;
    `CHK(n, 2)
    `CHK(ind_rd_data, lo ^ 8'h5C)
    `CHK(prog_rd_flash_addr, {hi[4:0], lo})
    `CHK(ind_prog_sel, hi[7])
  endtask

  initial
  begin
    {clk_sys, rstn, bulk_erase, nvm_wr_req, write_error_clr, cfg_rd_en} = 6'h00;
    {fetch_valid, exec_violation_flag_set, ind_rd_en, ind_wr_en} = 4'h0;
    {nvm_wr_addr, cfg_rd_addr, nvm_wr_data, fetch_addr} = 61'h0;
    {pointer_high_byte, pointer_low_byte} = 16'h0000;
    repeat (5) @(negedge clk_sys);
    rstn = 1;
    `CHK(reset_vector, 15'h0000)
    `CHK(intr_vector, 15'h0004)
    rd(16'h8005, {2'b10, 6'h2A, 6'h15});
    rd(16'h8006, {2'b11, 12'hC3A});
    rd(16'h800B, 14'h3FFF);
    rd(16'h8010, 14'h0000);
    wr(16'h0000, 14'h1234, 1);
    wr(16'h1FFF, 14'h0000, 1);
    fetch(15'h1FFF, 0);
    wr(16'h8005, 14'h0000, 0);
    for (int i = 0; i < 5; i++)
    begin
      erase();
      wr(16'h800A, 14'h3EF0 | {11'h0, codes[i]}, 1);
      `CHK(boot_region_size_sel, codes[i])
      wr(16'h800A, 14'h3EF0, 1);
      `CHK(boot_region_size_sel, codes[i])
      wr({3'h0, lasts[i]}, 14'h0000, 0);
      wr({3'h0, lasts[i] + 13'h0001}, 14'h0000, 1);
    end
    erase();
    wr(16'h800A, 14'h37EF, 1);
    wr(16'h1F80, 14'h0000, 0);
    wr(16'h1F7F, 14'h0000, 1);
    fetch(15'h7F80, 1);
    @(negedge clk_sys);
    exec_violation_flag_set = 1;
    @(negedge clk_sys);
    exec_violation_flag_set = 0;
    `CHK(exec_violation_flag_n, 1'b1)
    fetch(15'h1F7F, 0);
    wr(16'h800A, 14'h3FFF, 1);
    `CHK(storage_region_enable_n, 1'b0)
    erase();
    `CHK(storage_region_enable_n, 1'b1)
    wr(16'h800B, 14'h0000, 1);
    `CHK(flash_read_protect_n, 1'b0)
    rd(16'h800B, 14'h3FFE);
    wr(16'h800A, 14'h3DFF, 1);
    wr(16'h800B, 14'h3FFF, 0);
    ir(8'h80, 8'h34);
    ir(8'h9F, 8'hFF);
    @(negedge clk_sys);
    ind_wr_en = 1;
    pointer_high_byte = 8'h81;
    @(negedge clk_sys);
    ind_wr_en = 0;
    `CHK(ind_wr_ignored, 1'b1)
    end_of_test();
  end
endmodule
